//--- tsc_regmap.sv
// result and pin register map behind the serial register port
//
// Notes on behaviour
// - read address 10000 returns the vertical touch coordinate
// - read address 10001 returns the horizontal touch coordinate
// - read address 10010 returns the second pressure term
// - auxiliary inputs one to three read at 10011, 10100, 10101
// - battery inputs one and two read at 10110 and 10111
// - temperature single-ended at 11000, differential at 11001
// - read address 11010 returns the first pressure term
// - results are 12 bits, reset to zero, never written by the host
// - extended writes carry 1111 then a 4-bit index on top
// - only the low eight bits of an extended write are stored
// - config one at index 0 reads 11011, config two index 1 reads 11100
// - alert enable set lets the pin drive alert, clear masks it
// - direction bit zero makes an output, one an input
// - polarity bit zero active low, one active high
// - function select zero analog input, one general-purpose pin
// - config two holds pin four low nibble, pin three high, bit 3 unused
// - config two bit 7 selects pin three; pin four has no select
// - pin level register index 2, reads 11101, bits 7..4 pins one..four
`timescale 1ns/1ps
module tsc_regmap (
    input  wire logic                         CLK_I,
    input  wire logic                         RESET_I,
    input  wire logic                         CE_I,
    input  wire logic                         SCLK_I,
    input  wire logic                         CS_N_I,
    input  wire logic                         DIN_I,
    output logic                              DOUT_O,
    input  wire logic                         RESULT_LOAD_I,
    input  wire tsc_regmap_pkg::tsc_rd_addr_t RESULT_ADDR_I,
    input  wire tsc_regmap_pkg::tsc_result_t  RESULT_VALUE_I,
    input  wire logic [3:0]                   PIN_I,
    output logic      [3:0]                   PIN_O,
    output logic      [3:0]                   PIN_OE_O,
    output logic      [3:0]                   PIN_FUNC_GPIO_O,
    output logic                              ALERT_O
);
    import tsc_regmap_pkg::*;
    `include "tsc_regmap_consts.svh"

    // ======================================================================
    // state
    typedef struct packed {
        tsc_state_t                          state;
        logic [3:0]                          bit_cnt;
        logic [`TSC_WORD_BITS-1:0]           rx;
        logic [`TSC_WORD_BITS-1:0]           tx;
        tsc_rd_addr_t                        rd_addr;
        logic                                sclk_prev;
        logic                                cs_n_prev;
        logic                                seen_rise;
        logic [`TSC_RESULT_COUNT-1:0][11:0]  result;
        tsc_pin_reg_t                        pin_config_first_pair;
        tsc_pin_reg_t                        pin_config_second_pair;
        tsc_pin_reg_t                        pin_level_register;
        logic                                dout;
        logic [3:0]                          pin_out;
        logic [3:0]                          pin_oe;
        logic [3:0]                          pin_func;
        logic                                alert;
    } tsc_regs_t;

    tsc_regs_t r;
    tsc_regs_t next_r;

    // ======================================================================
    // pin synchronisers
    logic [6:0] sync_out;
    logic       sclk_s;
    logic       cs_n_s;
    logic       din_s;
    logic [3:0] pin_s;

    // serial pins come from the host's clock, so all pass two flops
    tsc_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .ce_i    (CE_I),
        .async_i ({PIN_I, DIN_I, ~CS_N_I, SCLK_I}),
        .sync_o  (sync_out)
    );

    // select travels inverted: the flops clear to zero, which must read as
    // deselected, or a false frame start would follow every reset
    assign sclk_s = sync_out[0];
    assign cs_n_s = ~sync_out[1];
    assign din_s  = sync_out[2];
    assign pin_s  = sync_out[6:3];

    // ======================================================================
    // pin cells
    logic [3:0] ctl_nib [4];
    logic [3:0] data_bit;
    logic [3:0] cell_oe;
    logic [3:0] cell_out;
    logic [3:0] cell_alert;
    logic [3:0] cell_read;

    // index 0..3 = pin one..four
    always_comb begin
        ctl_nib[0]  = r.pin_config_first_pair[7:4];
        ctl_nib[1]  = r.pin_config_first_pair[3:0];
        // pin three sits in the high nibble of config two
        ctl_nib[2]  = r.pin_config_second_pair[7:4];
        // pin four has no select, so it is always a pin
        ctl_nib[3]  = {1'b1, r.pin_config_second_pair[2:0]};
        // data bits run pin one at bit 7 down to pin four at bit 4
        data_bit[0] = r.pin_level_register[`TSC_PIN_ONE_DATA_BIT];
        data_bit[1] = r.pin_level_register[`TSC_PIN_TWO_DATA_BIT];
        data_bit[2] = r.pin_level_register[`TSC_PIN_THREE_DATA_BIT];
        data_bit[3] = r.pin_level_register[`TSC_PIN_FOUR_DATA_BIT];
    end

    // each cell sees only its own alert enable
    // pin one
    tsc_pin_cell u_cell_one (
        .ctl_i   (ctl_nib[0]),
        .data_i  (data_bit[0]),
        .level_i (pin_s[0]),
        .oe_o    (cell_oe[0]),
        .out_o   (cell_out[0]),
        .alert_o (cell_alert[0]),
        .read_o  (cell_read[0])
    );

    // pin two
    tsc_pin_cell u_cell_two (
        .ctl_i   (ctl_nib[1]),
        .data_i  (data_bit[1]),
        .level_i (pin_s[1]),
        .oe_o    (cell_oe[1]),
        .out_o   (cell_out[1]),
        .alert_o (cell_alert[1]),
        .read_o  (cell_read[1])
    );

    // pin three
    tsc_pin_cell u_cell_three (
        .ctl_i   (ctl_nib[2]),
        .data_i  (data_bit[2]),
        .level_i (pin_s[2]),
        .oe_o    (cell_oe[2]),
        .out_o   (cell_out[2]),
        .alert_o (cell_alert[2]),
        .read_o  (cell_read[2])
    );

    // pin four
    tsc_pin_cell u_cell_four (
        .ctl_i   (ctl_nib[3]),
        .data_i  (data_bit[3]),
        .level_i (pin_s[3]),
        .oe_o    (cell_oe[3]),
        .out_o   (cell_out[3]),
        .alert_o (cell_alert[3]),
        .read_o  (cell_read[3])
    );

    // ======================================================================
    // readback mux
    logic [`TSC_WORD_BITS-1:0] read_word;

    // results sit in read address order, index 0 at 10000
    always_comb begin
        read_word = '0;
        if (r.rd_addr == `TSC_RD_Y_POSITION) begin
            read_word = {4'h0, r.result[0]};
        end else if (r.rd_addr == `TSC_RD_X_POSITION) begin
            read_word = {4'h0, r.result[1]};
        end else if (r.rd_addr == `TSC_RD_PRESSURE_B) begin
            read_word = {4'h0, r.result[2]};
        end else if (r.rd_addr == `TSC_RD_AUX_ONE) begin
            read_word = {4'h0, r.result[3]};
        end else if (r.rd_addr == `TSC_RD_AUX_TWO) begin
            read_word = {4'h0, r.result[4]};
        end else if (r.rd_addr == `TSC_RD_AUX_THREE) begin
            read_word = {4'h0, r.result[5]};
        end else if (r.rd_addr == `TSC_RD_BAT_ONE) begin
            read_word = {4'h0, r.result[6]};
        end else if (r.rd_addr == `TSC_RD_BAT_TWO) begin
            read_word = {4'h0, r.result[7]};
        end else if (r.rd_addr == `TSC_RD_TEMP_SINGLE) begin
            read_word = {4'h0, r.result[8]};
        end else if (r.rd_addr == `TSC_RD_TEMP_DIFF) begin
            read_word = {4'h0, r.result[9]};
        end else if (r.rd_addr == `TSC_RD_PRESSURE_A) begin
            read_word = {4'h0, r.result[10]};
        // config registers read back at 11011 and 11100
        end else if (r.rd_addr == `TSC_RD_PIN_CFG_ONE) begin
            read_word = {8'h00, r.pin_config_first_pair};
        end else if (r.rd_addr == `TSC_RD_PIN_CFG_TWO) begin
            read_word = {8'h00, r.pin_config_second_pair};
        // unused low bits of the level register read zero
        end else if (r.rd_addr == `TSC_RD_PIN_LEVEL) begin
            read_word = {8'h00, cell_read[0], cell_read[1], cell_read[2], cell_read[3], 4'h0};
        end
    end

    // ======================================================================
    // next state
    logic                      sclk_rise;
    logic                      sclk_fall;
    logic                      cs_fall;
    logic [`TSC_WORD_BITS-1:0] word;
    logic [3:0]                prefix;
    logic [3:0]                ext_index;

    always_comb begin
        next_r    = r;
        sclk_rise = sclk_s & ~r.sclk_prev;
        sclk_fall = ~sclk_s & r.sclk_prev;
        cs_fall   = ~cs_n_s & r.cs_n_prev;
        word      = {r.rx[`TSC_WORD_BITS-2:0], din_s};
        prefix    = word[`TSC_PREFIX_MSB:`TSC_PREFIX_LSB];
        ext_index = word[`TSC_EXT_INDEX_MSB:`TSC_EXT_INDEX_LSB];

        next_r.sclk_prev = sclk_s;
        next_r.cs_n_prev = cs_n_s;

        // results change only by the converter load, never by the host
        if (RESULT_LOAD_I) begin
            if (RESULT_ADDR_I == `TSC_RD_Y_POSITION) begin
                next_r.result[0] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_X_POSITION) begin
                next_r.result[1] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_PRESSURE_B) begin
                next_r.result[2] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_AUX_ONE) begin
                next_r.result[3] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_AUX_TWO) begin
                next_r.result[4] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_AUX_THREE) begin
                next_r.result[5] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_BAT_ONE) begin
                next_r.result[6] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_BAT_TWO) begin
                next_r.result[7] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_TEMP_SINGLE) begin
                next_r.result[8] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_TEMP_DIFF) begin
                next_r.result[9] = RESULT_VALUE_I;
            end else if (RESULT_ADDR_I == `TSC_RD_PRESSURE_A) begin
                next_r.result[10] = RESULT_VALUE_I;
            end
        end

        // frame sequencer
        case (r.state)
            TSC_IDLE: begin
                next_r.bit_cnt   = 4'h0;
                next_r.seen_rise = 1'b0;
                if (cs_fall) begin
                    next_r.state = TSC_SHIFT;
                    next_r.tx    = read_word;
                end
            end
            TSC_SHIFT: begin
                if (cs_n_s) begin
                    // short frames are dropped whole
                    next_r.state = TSC_IDLE;
                end else if (sclk_rise) begin
                    next_r.rx        = word;
                    next_r.bit_cnt   = r.bit_cnt + 4'h1;
                    next_r.seen_rise = 1'b1;
                    if (r.bit_cnt == 4'hF) begin
                        next_r.state = TSC_DONE;
                        // extended write map selected by the 1111 prefix
                        if (prefix == `TSC_EXT_PREFIX) begin
                            // only the low byte is kept
                            if (ext_index == `TSC_EXT_PIN_CFG_ONE) begin
                                next_r.pin_config_first_pair = word[7:0];
                            // bit 3 of config two is not stored
                            end else if (ext_index == `TSC_EXT_PIN_CFG_TWO) begin
                                next_r.pin_config_second_pair = word[7:0] & `TSC_CFG_TWO_MASK;
                            end else if (ext_index == `TSC_EXT_PIN_LEVEL) begin
                                next_r.pin_level_register = word[7:0] & `TSC_PIN_LEVEL_MASK;
                            end
                        end else if (prefix == `TSC_READ_PREFIX) begin
                            next_r.rd_addr = word[`TSC_RD_ADDR_MSB:`TSC_RD_ADDR_LSB];
                        end
                    end
                end else if (sclk_fall && r.seen_rise) begin
                    next_r.tx = {r.tx[`TSC_WORD_BITS-2:0], 1'b0};
                end
            end
            TSC_DONE: begin
                // extra clocks in a frame are ignored
                if (cs_n_s) begin
                    next_r.state = TSC_IDLE;
                end
            end
            default: begin
                next_r.state = TSC_IDLE;
            end
        endcase

        next_r.dout = (next_r.state == TSC_SHIFT) ? next_r.tx[`TSC_WORD_BITS-1] : 1'b0;

        // pin outputs registered so the pads see no decode glitches
        next_r.pin_oe   = cell_oe;
        next_r.pin_out  = cell_out;
        next_r.pin_func = {ctl_nib[3][3], ctl_nib[2][3], ctl_nib[1][3], ctl_nib[0][3]};
        // alert asserted while any unmasked general-purpose input pin is active
        next_r.alert    = |cell_alert;
    end

    // ======================================================================
    // state register
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r                        <= '0;
            r.state                  <= TSC_IDLE;
            r.cs_n_prev              <= 1'b1;
            // pin four has no select and resets as an output, so it is driven
            r.pin_oe                 <= `TSC_PIN_FOUR_ONLY;
            r.pin_func               <= `TSC_PIN_FOUR_ONLY;
            r.result                 <= {`TSC_RESULT_COUNT{`TSC_RESULT_RESET}};
            r.pin_config_first_pair  <= `TSC_PIN_REG_RESET;
            r.pin_config_second_pair <= `TSC_PIN_REG_RESET;
            r.pin_level_register     <= `TSC_PIN_REG_RESET;
        end else if (CE_I) begin
            r <= next_r;
        end
    end

    // ======================================================================
    // outputs
    assign DOUT_O          = r.dout;
    assign PIN_O           = r.pin_out;
    assign PIN_OE_O        = r.pin_oe;
    assign PIN_FUNC_GPIO_O = r.pin_func;
    assign ALERT_O         = r.alert;

endmodule : tsc_regmap

//--- tsc_regmap_consts.svh
// constant offsets, field positions and reset values of the result and pin register map
`ifndef TSC_REGMAP_CONSTS_SVH
`define TSC_REGMAP_CONSTS_SVH

// ==========================================================================
// serial word layout
`define TSC_WORD_BITS          16
`define TSC_PREFIX_MSB         15
`define TSC_PREFIX_LSB         12
`define TSC_EXT_PREFIX         4'hF
`define TSC_READ_PREFIX        4'hB
`define TSC_EXT_INDEX_MSB      11
`define TSC_EXT_INDEX_LSB      8
`define TSC_RD_ADDR_MSB        11
`define TSC_RD_ADDR_LSB        7

// ==========================================================================
// read addresses
`define TSC_RD_Y_POSITION      5'h10
`define TSC_RD_X_POSITION      5'h11
`define TSC_RD_PRESSURE_B      5'h12
`define TSC_RD_AUX_ONE         5'h13
`define TSC_RD_AUX_TWO         5'h14
`define TSC_RD_AUX_THREE       5'h15
`define TSC_RD_BAT_ONE         5'h16
`define TSC_RD_BAT_TWO         5'h17
`define TSC_RD_TEMP_SINGLE     5'h18
`define TSC_RD_TEMP_DIFF       5'h19
`define TSC_RD_PRESSURE_A      5'h1A
`define TSC_RD_PIN_CFG_ONE     5'h1B
`define TSC_RD_PIN_CFG_TWO     5'h1C
`define TSC_RD_PIN_LEVEL       5'h1D
`define TSC_RESULT_COUNT       11

// ==========================================================================
// extended write indexes
`define TSC_EXT_PIN_CFG_ONE    4'h0
`define TSC_EXT_PIN_CFG_TWO    4'h1
`define TSC_EXT_PIN_LEVEL      4'h2

// ==========================================================================
// field positions and masks
`define TSC_CTL_ALERT_BIT      0
`define TSC_CTL_DIR_BIT        1
`define TSC_CTL_POL_BIT        2
`define TSC_CTL_FSEL_BIT       3
`define TSC_PIN_ONE_DATA_BIT   7
`define TSC_PIN_TWO_DATA_BIT   6
`define TSC_PIN_THREE_DATA_BIT 5
`define TSC_PIN_FOUR_DATA_BIT  4
`define TSC_CFG_TWO_MASK       8'hF7
`define TSC_PIN_LEVEL_MASK     8'hF0

// ==========================================================================
// reset values
`define TSC_RESULT_RESET       12'h000
`define TSC_PIN_REG_RESET      8'h00
`define TSC_PIN_FOUR_ONLY      4'h8

`endif

//--- tsc_regmap_pkg.sv
// types shared by the result and pin register map
package tsc_regmap_pkg;

    // gray coded along idle -> shift -> done
    typedef enum logic [1:0] {
        TSC_IDLE  = 2'b00,
        TSC_SHIFT = 2'b01,
        TSC_DONE  = 2'b11
    } tsc_state_t;

    typedef logic [11:0] tsc_result_t;
    typedef logic [7:0]  tsc_pin_reg_t;
    typedef logic [4:0]  tsc_rd_addr_t;

endpackage : tsc_regmap_pkg

//--- tsc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] first_stage;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_stage <= '0;
            sync_o      <= '0;
        end else if (ce_i) begin
            first_stage <= async_i;
            sync_o      <= first_stage;
        end
    end
endmodule : tsc_sync

//--- tsc_pin_cell.sv
// decode of one general-purpose pin from its control nibble
`timescale 1ns/1ps
module tsc_pin_cell (
    input  wire logic [3:0] ctl_i,
    input  wire logic       data_i,
    input  wire logic       level_i,
    output logic            oe_o,
    output logic            out_o,
    output logic            alert_o,
    output logic            read_o
);
    `include "tsc_regmap_consts.svh"

    logic is_gpio;
    logic is_input;

    always_comb begin
        is_gpio  = ctl_i[`TSC_CTL_FSEL_BIT];
        is_input = ctl_i[`TSC_CTL_DIR_BIT];
        oe_o     = is_gpio & ~is_input;
        out_o    = data_i;
        // active level picked by polarity; alert enable masks the pin
        alert_o  = is_gpio & is_input & ctl_i[`TSC_CTL_ALERT_BIT]
                 & (level_i == ctl_i[`TSC_CTL_POL_BIT]);
        // input pins read the pin itself, output pins the stored bit
        read_o   = (is_gpio & is_input) ? level_i : data_i;
    end
endmodule : tsc_pin_cell

//--- tsc_host.sv
// host model that frames serial words toward the register map
`timescale 1ns/1ps
module tsc_host (
    input  wire logic clk_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o
);
    // ==========================================
    // serial frames
    // the serial clock stands low between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle

    // phases of 6 cycles leave margin over the 3-cycle minimum
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        cs_n_o = 1'b0;
        idle(6);
        for (int i = 15; i >= 0; i--) begin
            r[i]   = dout_i;
            din_o  = w[i];
            sclk_o = 1'b1;
            idle(6);
            sclk_o = 1'b0;
            idle(6);
        end
        idle(4);
        cs_n_o = 1'b1;
        din_o  = ~din_o; // released line must not look held
        idle(4);
    endtask : frame

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [15:0] r;
        frame({4'hF, idx, d}, r);
    endtask : wr

    // select frame, then a neutral frame that carries the answer
    task automatic rd(input logic [4:0] a, output logic [15:0] r);
        frame({4'hB, a, 7'h00}, r);
        frame(16'h0000, r);
    endtask : rd
endmodule : tsc_host

//--- tsc_regmap_asserts.sv
// port checker for the result and pin register map
`timescale 1ns/1ps
module tsc_regmap_asserts (
    input wire logic       CLK_I,
    input wire logic       RESET_I,
    input wire logic       CS_N_I,
    input wire logic [3:0] PIN_I,
    input wire logic       DOUT_O,
    input wire logic [3:0] PIN_O,
    input wire logic [3:0] PIN_OE_O,
    input wire logic [3:0] PIN_FUNC_GPIO_O,
    input wire logic       ALERT_O
);
    logic [4:0] cs_age;
    logic [4:0] pin_age;
    logic [3:0] pin_prev;

    // ==========================================
    // cause ages
    // ages saturate so a long idle never wraps into a false cause
    always_ff @(posedge CLK_I) begin
        pin_prev <= PIN_I;
        if (RESET_I) begin
            cs_age  <= 5'h1F;
            pin_age <= 5'h1F;
        end else begin
            cs_age  <= !CS_N_I ? 5'h00 : cs_age + {4'h0, cs_age != 5'h1F};
            pin_age <= (PIN_I != pin_prev) ? 5'h00 : pin_age + {4'h0, pin_age != 5'h1F};
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    // ==========================================
    // properties
    reset_values_a: assert property ($fell(RESET_I) |-> (!DOUT_O && !ALERT_O
        && PIN_O == 4'h0 && PIN_OE_O == 4'h8 && PIN_FUNC_GPIO_O == 4'h8)[*3])
        else $error("outputs left reset values");
    pin_four_gpio_a: assert property (PIN_FUNC_GPIO_O[3])
        else $error("pin four lost gpio function");
    drive_needs_gpio_a: assert property ((PIN_OE_O & ~PIN_FUNC_GPIO_O) == 4'h0)
        else $error("analog pin driven");
    alert_needs_input_a: assert property (ALERT_O |-> (PIN_FUNC_GPIO_O & ~PIN_OE_O) != 4'h0)
        else $error("alert without gpio input");
    config_after_write_a: assert property (!$stable({PIN_OE_O, PIN_FUNC_GPIO_O}) |-> cs_age <= 5'h14)
        else $error("pin config moved without frame");
    level_after_write_a: assert property ($changed(PIN_O) |-> $past(cs_age) <= 5'h13)
        else $error("pin level moved without frame");
    alert_cause_a: assert property ($changed(ALERT_O) |-> pin_age <= 5'h06 || cs_age <= 5'h14)
        else $error("alert moved without cause");
    dout_idle_a: assert property (CS_N_I[*6] |-> !DOUT_O)
        else $error("serial out active outside frame");
endmodule : tsc_regmap_asserts

bind tsc_regmap tsc_regmap_asserts u_chk (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .CS_N_I(CS_N_I),
    .PIN_I(PIN_I),
    .DOUT_O(DOUT_O),
    .PIN_O(PIN_O),
    .PIN_OE_O(PIN_OE_O),
    .PIN_FUNC_GPIO_O(PIN_FUNC_GPIO_O),
    .ALERT_O(ALERT_O)
);

//--- tsc_regmap_bench.sv
// self-checking bench for the result and pin register map
`timescale 1ns/1ps
module tsc_regmap_bench;
    import tsc_regmap_pkg::*;
    logic         clk;
    logic         rst;
    logic         ce;
    logic         load;
    tsc_rd_addr_t laddr;
    tsc_result_t  lval;
    logic [3:0]   pin_ext;
    logic [3:0]   pin_wire;
    logic [3:0]   pin_o;
    logic [3:0]   pin_oe;
    logic [3:0]   pin_fn;
    logic         alert;
    logic         sclk;
    logic         cs_n;
    logic         din;
    logic         dout;
    logic [15:0]  r;
    int           failures = 0;
    int           n_checks = 0;
    int           cyc = 0;

    // a driven pin shows its own value, an input pin the outside level
    assign pin_wire = (pin_oe & pin_o) | (~pin_oe & pin_ext);

    // clock enable driven by the bench so a freeze can be checked
    tsc_regmap dut (
        .CLK_I(clk),
        .RESET_I(rst),
        .CE_I(ce),
        .SCLK_I(sclk),
        .CS_N_I(cs_n),
        .DIN_I(din),
        .DOUT_O(dout),
        .RESULT_LOAD_I(load),
        .RESULT_ADDR_I(laddr),
        .RESULT_VALUE_I(lval),
        .PIN_I(pin_wire),
        .PIN_O(pin_o),
        .PIN_OE_O(pin_oe),
        .PIN_FUNC_GPIO_O(pin_fn),
        .ALERT_O(alert)
    );
    tsc_host host (
        .clk_i(clk),
        .dout_i(dout),
        .sclk_o(sclk),
        .cs_n_o(cs_n),
        .din_o(din)
    );

    // ==========================================
    // clock, ceiling and shared tasks
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the run needs about 15k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        host.rd(a, r);
        chk(r, exp); // readback word
    endtask : rchk

    task automatic do_reset();
        rst = 1'b1;
        host.idle(8);
        rst = 1'b0;
        host.idle(4);
    endtask : do_reset

    // ==========================================
    // scenarios
    // loads every result plus one out-of-range address, then tries stray writes
    task automatic t_results();
        for (int a = 16; a <= 27; a++) begin
            @(negedge clk);
            load  = 1'b1;
            laddr = a[4:0];
            lval  = 12'(a * 147);
        end
        @(negedge clk);
        load = 1'b0;
        host.wr(4'h3, 8'hFF);
        host.frame(16'h1FFF, r);
        for (int a = 16; a <= 26; a++) begin
            rchk(a[4:0], {4'h0, 12'(a * 147)});
        end
        rchk(5'h1B, 16'h0000);
        $display("done t_results");
    endtask : t_results

    task automatic t_pins();
        host.wr(4'h1, 8'hFF);
        rchk(5'h1C, 16'h00F7);
        host.wr(4'h0, 8'hFF);
        rchk(5'h1B, 16'h00FF);
        host.wr(4'h0, 8'h88);
        host.wr(4'h1, 8'h80);
        host.wr(4'h2, 8'hA5);
        rchk(5'h1D, 16'h00A0);
        chk({4'h0, pin_fn, pin_oe, pin_o}, 16'h0FF5);
        $display("done t_pins");
    endtask : t_pins

    // second reset in mid-run, after pins and results were set
    task automatic t_reset();
        do_reset();
        chk({dout, alert, 2'h0, pin_fn, pin_oe, pin_o}, 16'h0880);
        for (int a = 16; a <= 29; a++) begin
            rchk(a[4:0], 16'h0000);
        end
        $display("done t_reset");
    endtask : t_reset

    task automatic t_alert();
        host.wr(4'h1, 8'hF6);
        chk({8'h0, pin_fn, pin_oe}, 16'h00C0);
        pin_ext = 4'b1000;
        host.idle(8);
        chk({15'h0, alert}, 16'h0000);
        pin_ext = 4'b1100;
        host.idle(8);
        chk({15'h0, alert}, 16'h0001);
        rchk(5'h1D, 16'h0030);
        host.wr(4'h1, 8'hB6);
        chk({15'h0, alert}, 16'h0000);
        pin_ext = 4'b1000;
        host.idle(8);
        chk({15'h0, alert}, 16'h0001);
        host.wr(4'h1, 8'hA6);
        chk({15'h0, alert}, 16'h0000);
        $display("done t_alert");
    endtask : t_alert

    // a frame sent while frozen must leave no trace, and the port works after
    task automatic t_freeze();
        ce = 1'b0;
        host.wr(4'h1, 8'hB6);
        chk({15'h0, alert}, 16'h0000);
        ce = 1'b1;
        host.idle(8);
        rchk(5'h1C, 16'h00A6);
        host.wr(4'h1, 8'hB6);
        chk({15'h0, alert}, 16'h0001);
        $display("done t_freeze");
    endtask : t_freeze

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst     = 1'b1;
        ce      = 1'b1;
        load    = 1'b0;
        laddr   = 5'h00;
        lval    = 12'h000;
        pin_ext = 4'h0;
        do_reset();
        t_results();
        t_pins();
        t_reset();
        t_alert();
        t_freeze();
        end_of_test();
    end
endmodule : tsc_regmap_bench
